// *** common/vpq_pkg.sv ***
// package for the vlan priority queue mapper: register map, fields, resets
package vpq_pkg;
  // register addresses (8-bit register space)
  localparam logic [7:0] VPQ_MAP_LO_ADDR     = 8'h80;
  localparam logic [7:0] VPQ_MAP_HI_ADDR     = 8'h81;
  localparam logic [7:0] VPQ_COLLAPSE_ADDR   = 8'h82;
  // reset values
  localparam logic [7:0] VPQ_MAP_LO_RST      = 8'h50;
  localparam logic [7:0] VPQ_MAP_HI_RST      = 8'hfa;
  localparam logic [1:0] VPQ_COLLAPSE_RST    = 2'h2;
  // read-only low bits of the collapse register
  localparam logic [5:0] VPQ_COLLAPSE_RO_VAL = 6'h04;
  // field positions
  localparam int         VPQ_FIELD_W         = 2;
  localparam int         VPQ_COLLAPSE_LSB    = 6;
  // queue numbers
  localparam logic [1:0] VPQ_PRIO_LOWEST     = 2'h0;
  localparam logic [1:0] VPQ_PRIO_HIGHEST    = 2'h3;
  localparam logic [1:0] VPQ_PRIO_MID_LO     = 2'h1;
  localparam logic [1:0] VPQ_PRIO_MID_HI     = 2'h2;

  typedef enum logic [0:0]
  {
    VPQ_MODE_FOUR = 1'b0,
    VPQ_MODE_TWO  = 1'b1
  } vpq_mode_t;
endpackage

// *** common/vpq_map_if.sv ***
// interface carrying the mapping configuration into the classifier
`timescale 1ns/1ps
interface vpq_map_if;
  logic [15:0] map_fields;
  logic [1:0]  collapse_ctrl;

  modport regs (output map_fields, output collapse_ctrl);
  modport cls  (input map_fields, input collapse_ctrl);
endinterface

// *** core/vpq_classify.sv ***
// classifier: 802.1p code to internal priority and queue select
`timescale 1ns/1ps
module vpq_classify
  import vpq_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // configuration
  vpq_map_if.cls          cfg,
  // classification request
  input  wire logic       req_valid,
  input  wire logic [2:0] req_pcp,
  input  wire logic       req_use_ext,
  input  wire logic [1:0] req_ext_prio,
  input  wire vpq_mode_t  req_mode,
  // result
  output logic            res_valid,
  output logic [1:0]      res_prio,
  output logic [1:0]      res_queue
);
  logic [1:0] fld [8];
  logic [1:0] prio_d;
  logic [1:0] queue_d;

  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : g_fld
      assign fld[g] = cfg.map_fields[g*VPQ_FIELD_W +: VPQ_FIELD_W];
    end
  endgenerate

  always_comb
  begin
    prio_d = req_use_ext ? req_ext_prio : fld[req_pcp];
    queue_d = prio_d;
    if (req_mode == VPQ_MODE_TWO)
    begin
      // only high (1) or low (0) queue in two-queue mode
      case (prio_d)
        VPQ_PRIO_LOWEST:  queue_d = 2'h0;
        VPQ_PRIO_MID_LO:  queue_d = {1'b0, cfg.collapse_ctrl[0]};
        VPQ_PRIO_MID_HI:  queue_d = {1'b0, cfg.collapse_ctrl[1]};
        VPQ_PRIO_HIGHEST: queue_d = 2'h1;
        default:          queue_d = 2'h0;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      res_valid <= 1'b0;
      res_prio  <= 2'h0;
      res_queue <= 2'h0;
    end
    else
    begin
      res_valid <= req_valid;
      if (req_valid)
      begin
        res_prio  <= prio_d;
        res_queue <= queue_d;
      end
    end
  end
endmodule // vpq_classify

// *** core/vpq_mapper.sv ***
// top: mapping registers and priority classifier
// Contract
// - queues are numbered 0..3; 3 is highest priority, 0 lowest.
// - a tagged frame's 3-bit code picks one of eight 2-bit fields as priority.
// - register 0x80 holds fields for codes 0..3, resets 0,0,1,1.
// - register 0x81 holds fields for codes 4..7, resets 2,2,3,3.
// - two-queue mode collapses the 2-bit result via bits 7..6 of 0x82.
// - result 0 low, 3 high, 1 follows bit 0, 2 follows bit 1.
`timescale 1ns/1ps
module vpq_mapper
  import vpq_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // register access
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic [7:0]      reg_rdata,
  output logic            reg_hit,
  // frame classification
  input  wire logic       req_valid,
  input  wire logic [2:0] req_pcp,
  input  wire logic       req_use_ext,
  input  wire logic [1:0] req_ext_prio,
  input  wire logic       two_queue_mode,
  output logic            res_valid,
  output logic [1:0]      res_prio,
  output logic [1:0]      res_queue
);
  logic [7:0] map_lo_q;
  logic [7:0] map_hi_q;
  logic [1:0] collapse_q;
  logic [7:0] rdata_d;
  vpq_mode_t  mode;

  vpq_map_if cfg_if ();

  // priority map, codes 0..3
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      map_lo_q <= VPQ_MAP_LO_RST;
    else if (reg_wr && reg_addr == VPQ_MAP_LO_ADDR)
      map_lo_q <= reg_wdata;
  end

  // priority map, codes 4..7
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      map_hi_q <= VPQ_MAP_HI_RST;
    else if (reg_wr && reg_addr == VPQ_MAP_HI_ADDR)
      map_hi_q <= reg_wdata;
  end

  // collapse control; 01 is stored as written, software must avoid it
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      collapse_q <= VPQ_COLLAPSE_RST;
    else if (reg_wr && reg_addr == VPQ_COLLAPSE_ADDR)
      collapse_q <= reg_wdata[VPQ_COLLAPSE_LSB +: 2];
  end

  // read mux; unmapped addresses read zero
  always_comb
  begin
    case (reg_addr)
      VPQ_MAP_LO_ADDR:   rdata_d = map_lo_q;
      VPQ_MAP_HI_ADDR:   rdata_d = map_hi_q;
      VPQ_COLLAPSE_ADDR: rdata_d = {collapse_q, VPQ_COLLAPSE_RO_VAL};
      default:           rdata_d = 8'h00;
    endcase
  end

  // registered read data, held between reads
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= rdata_d;
  end

  assign reg_hit = (reg_addr == VPQ_MAP_LO_ADDR) || (reg_addr == VPQ_MAP_HI_ADDR) ||
                   (reg_addr == VPQ_COLLAPSE_ADDR);

  assign cfg_if.map_fields    = {map_hi_q, map_lo_q};
  assign cfg_if.collapse_ctrl = collapse_q;
  assign mode = two_queue_mode ? VPQ_MODE_TWO : VPQ_MODE_FOUR;

  vpq_classify u_cls
  (
    .clk          (clk),
    .sys_rst      (sys_rst),
    .cfg          (cfg_if.cls),
    .req_valid    (req_valid),
    .req_pcp      (req_pcp),
    .req_use_ext  (req_use_ext),
    .req_ext_prio (req_ext_prio),
    .req_mode     (mode),
    .res_valid    (res_valid),
    .res_prio     (res_prio),
    .res_queue    (res_queue)
  );
endmodule // vpq_mapper

// *** testbench/vpq_mapper_properties.sv ***
// checker: port properties of the priority mapper
`timescale 1ns/1ps
module vpq_mapper_properties
(
  // watched ports
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_hit,
  input wire logic       req_valid,
  input wire logic       two_queue_mode,
  input wire logic       res_valid,
  input wire logic [1:0] res_prio,
  input wire logic [1:0] res_queue
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  chk_res_one_edge: assert property (req_valid |=> res_valid) else $error("no result");
  chk_res_no_spur: assert property (!req_valid |=> !res_valid) else $error("extra result");
  chk_four_q_direct: assert property (
    res_valid && !$past(two_queue_mode) |-> res_queue == res_prio) else $error("four queue");
  chk_two_q_low: assert property (
    res_valid && $past(two_queue_mode) && res_prio == 2'h0 |-> res_queue == 2'h0)
    else $error("prio 0 not low");
  chk_two_q_high: assert property (
    res_valid && $past(two_queue_mode) && res_prio == 2'h3 |-> res_queue == 2'h1)
    else $error("prio 3 not high");
  chk_unmapped_zero: assert property (
    reg_rd && !reg_hit |=> reg_rdata == 8'h00) else $error("unmapped read");
  chk_ro_bits: assert property (
    reg_rd && reg_addr == 8'h82 |=> reg_rdata[5:0] == 6'h04) else $error("read-only bits");
  chk_hit_decode: assert property (reg_hit == (reg_addr inside {8'h80, 8'h81, 8'h82}))
    else $error("hit decode");
endmodule // vpq_mapper_properties
bind vpq_mapper vpq_mapper_properties u_chk
(
  .clk            (clk),
  .sys_rst        (sys_rst),
  .reg_rd         (reg_rd),
  .reg_addr       (reg_addr),
  .reg_rdata      (reg_rdata),
  .reg_hit        (reg_hit),
  .req_valid      (req_valid),
  .two_queue_mode (two_queue_mode),
  .res_valid      (res_valid),
  .res_prio       (res_prio),
  .res_queue      (res_queue)
);

// *** testbench/tb_top.sv ***
// self-checking bench for the priority mapper
`timescale 1ns/1ps
module tb_top;
  logic        clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, req_valid = 0;
  logic        req_use_ext = 0, two_queue_mode = 0, res_valid, reg_hit;
  logic [7:0]  reg_addr = 0, reg_wdata = 0, reg_rdata;
  logic [2:0]  req_pcp = 0;
  logic [1:0]  req_ext_prio = 0, res_prio, res_queue, ct;
  logic [15:0] mp;
  int          n_fail = 0, n_checks = 0;
  vpq_mapper dut
  (
    .clk            (clk),
    .sys_rst        (sys_rst),
    .reg_wr         (reg_wr),
    .reg_rd         (reg_rd),
    .reg_addr       (reg_addr),
    .reg_wdata      (reg_wdata),
    .reg_rdata      (reg_rdata),
    .reg_hit        (reg_hit),
    .req_valid      (req_valid),
    .req_pcp        (req_pcp),
    .req_use_ext    (req_use_ext),
    .req_ext_prio   (req_ext_prio),
    .two_queue_mode (two_queue_mode),
    .res_valid      (res_valid),
    .res_prio       (res_prio),
    .res_queue      (res_queue)
  );
  initial forever #12.5 clk = ~clk;
  task automatic ck(string nm, logic [7:0] e, logic [7:0] s);
    n_checks++;
    if (s !== e)
    begin
      n_fail++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic end_of_test();
    if (n_fail == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // optional write, then read straight after it
  task automatic rw(logic [7:0] a, logic w, logic [7:0] d, logic [7:0] e);
    @(posedge clk);
    reg_wr    <= w;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    ck("reg_rdata", e, reg_rdata);
  endtask
  function automatic logic [1:0] exp_q(logic [1:0] p, logic m);
    return m ? {1'b0, p == 2'h3 || (p == 2'h1 && ct[0]) || (p == 2'h2 && ct[1])} : p;
  endfunction
  task automatic cls(logic [2:0] p, logic u, logic [1:0] x, logic m);
    logic [1:0] ep;
    ep = u ? x : mp[2*p +: 2];
    @(posedge clk);
    req_valid      <= 1'b1;
    req_pcp        <= p;
    req_use_ext    <= u;
    req_ext_prio   <= x;
    two_queue_mode <= m;
    @(posedge clk);
    req_valid <= 1'b0;
    @(negedge clk);
    ck("res_prio", 8'(ep), 8'(res_prio));
    ck("res_queue", 8'(exp_q(ep, m)), 8'(res_queue));
  endtask
  initial
  begin
    logic [7:0] a, d;
    void'($urandom(14));
    mp = 16'hfa50;
    ct = 2'h2;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    rw(8'h80, 1'b0, 8'h00, 8'h50);
    rw(8'h81, 1'b0, 8'h00, 8'hfa);
    rw(8'h82, 1'b0, 8'h00, 8'h84);
    rw(8'h83, 1'b1, 8'hff, 8'h00);
    for (int i = 0; i < 16; i++)
      cls(i[2:0], 1'b0, 2'h0, i[3]);
    for (int i = 0; i < 80; i++)
    begin
      a = 8'h80 + 8'($urandom % 3);
      d = 8'($urandom);
      // software never programs 01 into the collapse control
      if (a == 8'h82 && d[7:6] == 2'h1)
        d[7] = 1'b1;
      if (a == 8'h80)
        mp[7:0] = d;
      if (a == 8'h81)
        mp[15:8] = d;
      if (a == 8'h82)
        ct = d[7:6];
      rw(a, 1'b1, d, a == 8'h82 ? {d[7:6], 6'h04} : d);
      cls(3'($urandom), 1'($urandom), 2'($urandom), 1'($urandom));
    end
    end_of_test();
  end
  initial
  begin
    #100us;
    n_fail++;
    end_of_test();
  end
endmodule // tb_top
